// file: modbus_poll_defs.vh
`ifndef MODBUS_POLL_DEFS_VH
`define MODBUS_POLL_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 125000000
`define BAUD_RATE 19200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
// inter-frame silence: 3.5 characters of 11 bits each
`define GAP_CYCLES ((35 * 11 * `BIT_CYCLES) / 10)

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SLAVE_ADDR 8'hcc
`define FUNC_READ_REGS 8'h04
`define FULL_START_REG 16'h0000
`define FULL_REG_COUNT 16'h007d
`define RESP_BYTE_COUNT 8'hfa
`define REQ_LEN 4'h8
`define RESP_LAST_IDX 8'hfe
`define DATA_FIRST_IDX 8'h03
`define CRC_LO_IDX 8'hfd
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_PRODUCT_ID 7'h00
`define REG_TEST_NUM_HI 7'h08
`define REG_TEST_NUM_LO 7'h09
`define REG_FAULT_BITMAP 7'h1c
`define REG_RESULT_FIRST 7'h38
`define REG_RESULT_LAST 7'h3f

// ----------------------------------------------------------------
// fault bitmap fields
// ----------------------------------------------------------------
`define FAULT_OPTICS 0
`define FAULT_LOW_FLOW 1
`define FAULT_HIGH_FLOW 2
`define FAULT_LOGGER 3
`define FAULT_WATER 4
`define FAULT_WIDTH 5
`define FAULT_RESET 5'h00

`endif

// file: byte_serializer.v
`timescale 1ns/100ps
`include "modbus_poll_defs.vh"

module byte_serializer #(
  parameter BIT_CYCLES = `BIT_CYCLES
) (
  input wire i_mclk, // system clock
  input wire i_rst_n, // async reset, active low
  input wire i_ce, // clock enable
  input wire i_valid, // byte offered
  input wire [7:0] i_data, // byte to send
  output wire o_ready, // can take a byte this cycle
  output wire o_busy, // character on the line
  output wire o_line // serial line, idle high
);

  reg busy;
  reg [9:0] shift;
  reg [3:0] bits_left;
  reg [15:0] cnt;

  assign o_ready = ~busy;
  assign o_busy = busy;
  assign o_line = shift[0];

  // 8n1 character: start, lsb first data, stop
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      shift <= 10'h3ff;
      bits_left <= 4'h0;
      cnt <= 16'h0000;
    end else if (i_ce) begin
      if (!busy) begin
        if (i_valid) begin
          busy <= 1'b1;
          shift <= {1'b1, i_data, 1'b0};
          bits_left <= 4'h9;
          cnt <= BIT_CYCLES[15:0] - 16'h0001;
        end
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else if (bits_left == 4'h0) begin
        busy <= 1'b0;
      end else begin
        shift <= {1'b1, shift[9:1]};
        bits_left <= bits_left - 4'h1;
        cnt <= BIT_CYCLES[15:0] - 16'h0001;
      end
    end
  end

endmodule

// file: modbus_register_poll_port.v
`timescale 1ns/100ps
`include "modbus_poll_defs.vh"

module modbus_register_poll_port #(
  parameter BIT_CYCLES = `BIT_CYCLES,
  parameter GAP_CYCLES = `GAP_CYCLES,
  parameter [15:0] PRODUCT_ID = 16'h5a5a // arbitrary value
) (
  input wire i_mclk, // system clock, 125 mhz
  input wire i_rst_n, // async reset, active low
  input wire i_ce, // clock enable, freezes all state when low
  input wire i_rx, // rs485 receive data pin
  input wire [`FAULT_WIDTH-1:0] i_fault_cond, // fault conditions now present
  input wire i_test_end, // one-cycle pulse at end of a test
  input wire [31:0] i_test_number, // running test number
  input wire [127:0] i_result_codes, // eight 16-bit result codes, code 0 low
  output wire o_tx, // rs485 transmit data pin
  output reg o_tx_en, // rs485 driver enable
  output wire [15:0] o_fault_bitmap // fault flags register
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_DRAIN = 2'd2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [15:0] crc_step;
    input [15:0] crc_in;
    input [7:0] data;
    integer k;
    reg [15:0] c;
    begin
      c = crc_in ^ {8'h00, data};
      for (k = 0; k < 8; k = k + 1) begin
        if (c[0]) begin
          c = (c >> 1) ^ `CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc_step = c;
    end
  endfunction

  function [15:0] reg_value;
    input [6:0] n;
    input [15:0] flags;
    input [31:0] tnum;
    input [127:0] codes;
    begin
      if (n == `REG_PRODUCT_ID) begin
        reg_value = PRODUCT_ID;
      end else if (n == `REG_TEST_NUM_HI) begin
        reg_value = tnum[31:16];
      end else if (n == `REG_TEST_NUM_LO) begin
        reg_value = tnum[15:0];
      end else if (n == `REG_FAULT_BITMAP) begin
        reg_value = flags;
      end else if (n >= `REG_RESULT_FIRST && n <= `REG_RESULT_LAST) begin
        reg_value = codes[{n[2:0], 4'h0} +: 16];
      end else begin
        reg_value = 16'h0000;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // fault flags
  // ----------------------------------------------------------------
  reg [15:0] fault_bitmap;

  assign o_fault_bitmap = fault_bitmap;

  // a condition present at test end keeps its bit, so set wins over clear
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_bitmap <= 16'h0000;
    end else if (i_ce) begin
      fault_bitmap[`FAULT_WIDTH-1:0] <= i_fault_cond |
        (i_test_end ? `FAULT_RESET : fault_bitmap[`FAULT_WIDTH-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // receive character
  // ----------------------------------------------------------------
  reg rx_meta;
  reg rx_sync;
  reg r_busy;
  reg [3:0] r_bit;
  reg [15:0] r_cnt;
  reg [7:0] r_shift;
  reg r_done;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      r_busy <= 1'b0;
      r_bit <= 4'h0;
      r_cnt <= 16'h0000;
      r_shift <= 8'h00;
      r_done <= 1'b0;
    end else if (i_ce) begin
      rx_meta <= i_rx;
      rx_sync <= rx_meta;
      r_done <= 1'b0;
      if (!r_busy) begin
        if (!rx_sync) begin
          r_busy <= 1'b1;
          r_bit <= 4'h0;
          r_cnt <= BIT_CYCLES[16:1];
        end
      end else if (r_cnt != 16'h0000) begin
        r_cnt <= r_cnt - 16'h0001;
      end else begin
        r_cnt <= BIT_CYCLES[15:0] - 16'h0001;
        if (r_bit == 4'h0) begin
          // glitch shorter than half a bit is not a start bit
          if (rx_sync) begin
            r_busy <= 1'b0;
          end else begin
            r_bit <= 4'h1;
          end
        end else if (r_bit <= 4'h8) begin
          r_shift <= {rx_sync, r_shift[7:1]};
          r_bit <= r_bit + 4'h1;
        end else begin
          r_busy <= 1'b0;
          r_done <= rx_sync;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // request framing
  // ----------------------------------------------------------------
  reg [1:0] state;
  reg [19:0] gap;
  reg [3:0] fr_cnt;
  reg [47:0] fr_hdr;
  reg [15:0] fr_crc;
  wire gap_hit;
  wire req_ok;

  assign gap_hit = (gap == GAP_CYCLES[19:0]);
  // only the full-map read is answered; a wrong header is silently dropped
  assign req_ok = (fr_cnt == `REQ_LEN) && (fr_crc == 16'h0000) &&
    (fr_hdr == {`SLAVE_ADDR, `FUNC_READ_REGS, `FULL_START_REG, `FULL_REG_COUNT});

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap <= 20'h00000;
      fr_cnt <= 4'h0;
      fr_hdr <= 48'h000000000000;
      fr_crc <= `CRC_INIT;
    end else if (i_ce) begin
      if (r_busy || !rx_sync || state != ST_IDLE) begin
        gap <= 20'h00000;
      end else if (!gap_hit) begin
        gap <= gap + 20'h00001;
      end
      if (state != ST_IDLE || gap_hit) begin
        // half duplex: our own echo never forms a request
        fr_cnt <= 4'h0;
        fr_crc <= `CRC_INIT;
      end else if (r_done && fr_cnt <= `REQ_LEN) begin
        fr_cnt <= fr_cnt + 4'h1;
        // residue of a good frame over its own crc is zero
        fr_crc <= crc_step(fr_crc, r_shift);
        if (fr_cnt < 4'h6) begin
          fr_hdr <= {fr_hdr[39:0], r_shift};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // response
  // ----------------------------------------------------------------
  reg [7:0] idx;
  reg [15:0] tx_crc;
  reg [7:0] tx_byte;
  wire [7:0] data_off;
  wire [15:0] cur_reg;
  wire tx_ready;
  wire tx_take;

  assign data_off = idx - `DATA_FIRST_IDX;
  // every source is an argument, so the assign follows a flag change mid-frame
  assign cur_reg = reg_value(data_off[7:1], fault_bitmap, i_test_number, i_result_codes);
  assign tx_take = (state == ST_SEND) && tx_ready;

  always @* begin
    if (idx == 8'h00) begin
      tx_byte = `SLAVE_ADDR;
    end else if (idx == 8'h01) begin
      tx_byte = `FUNC_READ_REGS;
    end else if (idx == 8'h02) begin
      tx_byte = `RESP_BYTE_COUNT;
    end else if (idx == `CRC_LO_IDX) begin
      tx_byte = tx_crc[7:0];
    end else if (idx == `RESP_LAST_IDX) begin
      tx_byte = tx_crc[15:8];
    end else if (!data_off[0]) begin
      tx_byte = cur_reg[15:8];
    end else begin
      tx_byte = cur_reg[7:0];
    end
  end

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      idx <= 8'h00;
      tx_crc <= `CRC_INIT;
      o_tx_en <= 1'b0;
    end else if (i_ce) begin
      case (state)
        ST_IDLE: begin
          if (gap_hit && req_ok) begin
            state <= ST_SEND;
            idx <= 8'h00;
            tx_crc <= `CRC_INIT;
            o_tx_en <= 1'b1;
          end
        end
        ST_SEND: begin
          // next byte loads as soon as the stop bit ends
          if (tx_take) begin
            if (idx < `CRC_LO_IDX) begin
              tx_crc <= crc_step(tx_crc, tx_byte);
            end
            if (idx == `RESP_LAST_IDX) begin
              state <= ST_DRAIN;
            end else begin
              idx <= idx + 8'h01;
            end
          end
        end
        ST_DRAIN: begin
          if (tx_ready) begin
            state <= ST_IDLE;
            o_tx_en <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          o_tx_en <= 1'b0;
        end
      endcase
    end
  end

  byte_serializer #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_ser (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(tx_take),
    .i_data(tx_byte),
    .o_ready(tx_ready),
    .o_busy(),
    .o_line(o_tx)
  );

endmodule

// file: poll_port_props.sv
`timescale 1ns/100ps
module poll_port_props #(
  parameter BIT_CYCLES = 16
) (
  input wire i_mclk, // clock
  input wire i_rst_n, // reset, active low
  input wire i_ce, // clock enable
  input wire [4:0] i_fault_cond, // fault conditions
  input wire i_test_end, // end of test
  input wire o_tx, // transmit pin
  input wire o_tx_en, // driver enable
  input wire [15:0] fault_bitmap // fault flags
);
  integer hi_run;
  integer en_run;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_run <= 0;
      en_run <= 0;
    end else if (i_ce) begin
      hi_run <= (o_tx_en && o_tx) ? hi_run + 1 : 0;
      en_run <= o_tx_en ? en_run + 1 : 0;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_upper_zero: assert property (fault_bitmap[15:5] == 11'h000)
    else $error("fault bitmap upper bits set");
  a_flags_accumulate: assert property (i_ce && !i_test_end |=>
    fault_bitmap[4:0] == ($past(fault_bitmap[4:0]) | $past(i_fault_cond)))
    else $error("fault flag lost or not set");
  a_end_reload: assert property (i_ce && i_test_end |=>
    fault_bitmap[4:0] == $past(i_fault_cond))
    else $error("fault flags wrong after test end");
  a_freeze_off: assert property (!i_ce |=> $stable(fault_bitmap))
    else $error("fault flags moved while disabled");
  a_idle_high: assert property (!o_tx_en |-> o_tx)
    else $error("line not idle high while driver off");
  a_start_bit: assert property ($rose(o_tx_en) |=> !o_tx)
    else $error("no start bit after driver on");
  a_no_gap: assert property (hi_run <= 9 * BIT_CYCLES + 4)
    else $error("gap inside response frame");
  a_frame_len: assert property ($fell(o_tx_en) |-> en_run >= 2550 * BIT_CYCLES
    && en_run <= 255 * (10 * BIT_CYCLES + 1) + 4)
    else $error("response frame length wrong");
endmodule
bind modbus_register_poll_port poll_port_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (
  .i_mclk(i_mclk),
  .i_rst_n(i_rst_n),
  .i_ce(i_ce),
  .i_fault_cond(i_fault_cond),
  .i_test_end(i_test_end),
  .o_tx(o_tx),
  .o_tx_en(o_tx_en),
  .fault_bitmap(o_fault_bitmap)
);

// file: modbus_master_model.sv
`timescale 1ns/100ps
module modbus_master_model #(
  parameter BIT_CYCLES = 16
) (
  input wire i_mclk, // clock
  input wire i_line, // response line
  input wire i_line_en, // response driver on
  output reg o_line // request line, biased idle high
);
  reg [7:0] rx_buf [0:254];
  integer rx_cnt;
  reg [7:0] rb;
  integer k;
  function [15:0] crc16(input [15:0] c, input [7:0] d);
    integer i;
    begin
      crc16 = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1)
        crc16 = crc16[0] ? (crc16 >> 1) ^ 16'ha001 : crc16 >> 1;
    end
  endfunction
  // no idle time between characters
  task send_byte(input [7:0] b);
    integer i;
    begin
      o_line = 1'b0;
      repeat (BIT_CYCLES) @(negedge i_mclk);
      for (i = 0; i < 8; i = i + 1) begin
        o_line = b[i];
        repeat (BIT_CYCLES) @(negedge i_mclk);
      end
      o_line = 1'b1;
      repeat (BIT_CYCLES) @(negedge i_mclk);
    end
  endtask
  task send_req(input [7:0] addr, input [7:0] cnt, input bad);
    reg [47:0] f;
    reg [15:0] c;
    integer i;
    begin
      f = {addr, 8'h04, 24'h000000, cnt};
      c = 16'hffff;
      rx_cnt = 0;
      for (i = 5; i >= 0; i = i - 1) begin
        c = crc16(c, f[i*8 +: 8]);
        send_byte(f[i*8 +: 8]);
      end
      c[0] = c[0] ^ bad;
      send_byte(c[7:0]);
      send_byte(c[15:8]);
    end
  endtask
  initial begin
    o_line = 1'b1;
    rx_cnt = 0;
    forever begin
      @(negedge i_mclk);
      if (i_line_en && !i_line && rx_cnt < 255) begin
        repeat (BIT_CYCLES / 2) @(negedge i_mclk);
        for (k = 0; k < 8; k = k + 1) begin
          repeat (BIT_CYCLES) @(negedge i_mclk);
          rb[k] = i_line;
        end
        repeat (BIT_CYCLES) @(negedge i_mclk);
        rx_buf[rx_cnt] = rb;
        rx_cnt = rx_cnt + 1;
      end
    end
  end
endmodule

// file: modbus_register_poll_port_tb.sv
`timescale 1ns/100ps
module modbus_register_poll_port_tb;
  localparam BITC = 16;
  localparam GAPC = 200;
  reg i_mclk;
  reg i_rst_n;
  reg i_ce;
  reg i_test_end;
  reg [4:0] i_fault_cond;
  reg [31:0] i_test_number;
  reg [127:0] i_result_codes;
  wire rx_line;
  wire o_tx;
  wire o_tx_en;
  wire [15:0] fault_bitmap;
  integer err_total;
  integer n_tests;
  integer i;
  integer k;
  reg [15:0] c;
  // product code value is arbitrary
  modbus_register_poll_port #(.BIT_CYCLES(BITC), .GAP_CYCLES(GAPC),
    .PRODUCT_ID(16'h1234)) dut (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_rx(rx_line),
    .i_fault_cond(i_fault_cond),
    .i_test_end(i_test_end),
    .i_test_number(i_test_number),
    .i_result_codes(i_result_codes),
    .o_tx(o_tx),
    .o_tx_en(o_tx_en),
    .o_fault_bitmap(fault_bitmap)
  );
  modbus_master_model #(.BIT_CYCLES(BITC)) m (
    .i_mclk(i_mclk),
    .i_line(o_tx),
    .i_line_en(o_tx_en),
    .o_line(rx_line)
  );
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge i_mclk);
  endtask
  function [15:0] reg_at(input integer n);
    reg_at = {m.rx_buf[3+2*n], m.rx_buf[4+2*n]};
  endfunction
  task t_faults;
    begin
      i_fault_cond = 5'h05;
      cyc(2);
      chk(fault_bitmap, 16'h0005);
      i_fault_cond = 5'h12;
      cyc(2);
      chk(fault_bitmap, 16'h0017);
      i_fault_cond = 5'h02;
      i_test_end = 1'b1;
      cyc(1);
      i_test_end = 1'b0;
      cyc(1);
      chk(fault_bitmap, 16'h0002);
      i_ce = 1'b0;
      i_fault_cond = 5'h08;
      cyc(2);
      chk(fault_bitmap, 16'h0002);
      i_ce = 1'b1;
      cyc(2);
      chk(fault_bitmap, 16'h000a);
      i_fault_cond = 5'h10;
      i_test_end = 1'b1;
      cyc(1);
      i_test_end = 1'b0;
      cyc(1);
      chk(fault_bitmap, 16'h0010);
    end
  endtask
  task t_full_read;
    begin
      i_test_number = 32'h0001_2345;
      i_result_codes = 128'h0107_0106_0105_0104_0103_0102_0101_0100;
      cyc(GAPC);
      m.send_req(8'hcc, 8'h7d, 1'b0);
      for (i = 0; i < 50000 && m.rx_cnt < 255; i = i + 1) cyc(1);
      if (m.rx_cnt < 255) begin
        err_total = err_total + 1;
        final_report;
      end
      chk(o_tx_en, 1'b1);
      chk({m.rx_buf[0], m.rx_buf[1], m.rx_buf[2]}, 24'hcc04fa);
      chk(reg_at(0), 16'h1234);
      chk(reg_at(1), 16'h0000);
      chk({reg_at(8), reg_at(9)}, 32'h0001_2345);
      chk(reg_at(28), 16'h0010);
      for (i = 0; i < 8; i = i + 1) chk(reg_at(56 + i), 16'h0100 + i);
      c = 16'hffff;
      for (i = 0; i < 253; i = i + 1) c = m.crc16(c, m.rx_buf[i]);
      chk({m.rx_buf[254], m.rx_buf[253]}, c);
      cyc(20);
      chk(o_tx_en, 1'b0);
    end
  endtask
  // wrong address, wrong count, corrupted checksum: all must stay silent
  task t_refused;
    for (k = 0; k < 3; k = k + 1) begin
      cyc(GAPC);
      m.send_req(k == 0 ? 8'hcd : 8'hcc, k == 1 ? 8'h7c : 8'h7d, k == 2);
      cyc(2 * GAPC);
      chk(m.rx_cnt, 0);
    end
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_test_end = 1'b0;
    i_fault_cond = 5'h00;
    i_test_number = 32'h0;
    i_result_codes = 128'h0;
    cyc(8);
    i_rst_n = 1'b1;
    cyc(4);
    t_faults;
    t_full_read;
    t_refused;
    final_report;
  end
endmodule
